// ### bench/secondary_fault_status_word_test.sv
// Purpose: self-checking bench for the secondary fault status word
// Assumes: comparator states come from the partner model
// Notes: a bench model predicts status, events and interrupt each round
`timescale 1ns/1ns
module secondary_fault_status_word_test;
    import sfsw_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic drive_high_i = 1'b0;
    localparam int PIN_DESAT_ALIAS = NPIN; // desat rides one bit above the pin vector
    logic [NPIN:0] want = '0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [DATA_W-1:0] status_o;
    logic irq_o;
    logic src, snk, clb, nov, nuv, pov, puv, sto, ilim, rail, regf, desat;
    logic [2:0] temp, sc, oc;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h2f03;
    logic [15:0] cfg, msk, s0, s1, s2, ev, got;
    // clock of 8 ns
    always #4 clk_i = ~clk_i;
    sfsw_partner i_sfsw_partner (.clk_i(clk_i), .want_i(want), .source_level_o(src),
        .sink_level_o(snk), .clamp_below_o(clb), .neg_over_o(nov), .neg_under_o(nuv),
        .pos_over_o(pov), .pos_under_o(puv), .clamp_sto_o(sto), .temp_hot_o(temp),
        .short_o(sc), .overcur_o(oc), .ilimit_o(ilim), .rail_o(rail), .reg_o(regf),
        .desat_o(desat));
    sfsw_status i_sfsw_status (.clk_i(clk_i), .rst_n_i(rst_n_i), .drive_high_i(drive_high_i),
        .source_level_i(src), .sink_level_i(snk), .clamp_below_i(clb), .neg_over_cmp_i(nov),
        .neg_under_cmp_i(nuv), .pos_over_cmp_i(pov), .pos_under_cmp_i(puv),
        .clamp_sto_i(sto), .temp_hot_i(temp), .short_cmp_i(sc), .overcur_cmp_i(oc),
        .reg_ilimit_i(ilim), .rail_fault_i(rail), .reg_fault_i(regf), .desat_cmp_i(desat),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .status_o(status_o), .irq_o(irq_o));
    // ------------------------------------------------------------
    // model, bus tasks and verdict
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // expected live status from config, comparator states and drive level
    function automatic logic [15:0] model(input logic [15:0] c, input logic [NPIN:0] p,
        input logic d);
        logic [15:0] s;
        s = '0;
        s[ST_GATE_LEVEL] = d ? p[PIN_SINK] : p[PIN_SRC];
        s[ST_GATE_MISMATCH] = s[ST_GATE_LEVEL] != d;
        s[ST_INT_REG] = p[PIN_REG];
        s[ST_INT_RAIL] = p[PIN_RAIL];
        s[ST_MILLER] = p[PIN_CLAMP];
        s[ST_NEG_OVER] = c[CF_NEG_EN] & p[PIN_NOV];
        s[ST_NEG_UNDER] = c[CF_NEG_EN] & p[PIN_NUV];
        s[ST_POS_OVER] = !c[CF_POS_OV_DIS] & p[PIN_POV];
        s[ST_POS_UNDER] = !c[CF_POS_UV_DIS] & p[PIN_PUV];
        s[ST_COLL_CLAMP] = c[CF_CLAMP_EN] & p[PIN_STO];
        s[ST_OVERTEMP] = |(p[PIN_TEMP +: 3] & c[CF_TEMP_EN +: 3]);
        s[ST_ILIMIT] = p[PIN_ILIM];
        s[ST_SHORT] = |(p[PIN_SC +: 3] & c[CF_CUR_EN +: 3]);
        s[ST_OVERCUR] = |(p[PIN_OC +: 3] & c[CF_CUR_EN +: 3]);
        s[ST_DESAT] = p[PIN_DESAT_ALIAS];
        return s;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read strobe one cycle, data taken in the next cycle, zero after it
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
        @(posedge clk_i);
        #1;
        chk(rdata_o, 16'h0000, "read data after its cycle");
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e, input string m);
        logic [15:0] d;
        rd(a, d);
        chk(d, e, m);
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rc(ADDR_STATUS, STATUS_RST, "status reset");
        rc(ADDR_CONFIG, CONFIG_RST, "config reset");
        rc(ADDR_EVENT, EVENT_RST, "event reset");
        rc(ADDR_MASK, MASK_RST, "mask reset");
        wr(4'h9, 16'hffff);
        rc(4'h9, 16'h0000, "unmapped read");
        rc(ADDR_CONFIG, CONFIG_RST, "config after unmapped write");
        s0 = model(16'h0000, '0, 1'b0);
        for (int i = 0; i < 60; i++) begin
            seed = xorshift(seed);
            cfg = seed[15:0];
            seed = xorshift(seed);
            msk = seed[15:0] & EVENT_BITS & 16'hbfff;
            wr(ADDR_CONFIG, cfg);
            wr(ADDR_MASK, msk);
            cfg = cfg & CFG_WMASK;
            s1 = model(cfg, want, drive_high_i);
            seed = xorshift(seed);
            want <= seed[NPIN:0];
            drive_high_i <= seed[31];
            repeat (13) @(posedge clk_i);
            #1;
            s2 = model(cfg, want, drive_high_i);
            ev = ((s1 & ~s0) | (s2 & ~s1)) & EVENT_BITS & 16'hbfff;
            chk(status_o, s2, "live status");
            rc(ADDR_STATUS, s2, "status read");
            rc(ADDR_CONFIG, cfg, "config readback");
            rd(ADDR_EVENT, got);
            chk(got & 16'hbfff, ev, "sticky events");
            chk({15'h0000, irq_o}, {15'h0000, |(ev & msk)}, "interrupt level");
            wr(ADDR_STATUS, ~s2);
            rc(ADDR_STATUS, s2, "status after write");
            wr(ADDR_EVENT, 16'hffff);
            rc(ADDR_EVENT, 16'h0000, "events cleared");
            chk({15'h0000, irq_o}, 16'h0000, "interrupt after clear");
            s0 = s2;
        end
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        #1;
        chk(status_o, STATUS_RST, "status in reset");
        chk({15'h0000, irq_o}, 16'h0000, "interrupt in reset");
        give_verdict();
    end
endmodule

// ### bench/sfsw_partner.sv
// Purpose: analog comparator and monitor model facing the status word block
// Assumes: the bench names the wanted comparator states as one pin vector
// Notes: outputs move 3 ns after the edge, so they arrive unrelated to sampling
`timescale 1ns/1ns
module sfsw_partner
    import sfsw_pkg::*;
(
    input wire logic clk_i, // paces the changes only
    input wire logic [NPIN:0] want_i, // wanted comparator states, desat on top
    output logic source_level_o, // source stage sensed high
    output logic sink_level_o, // sink stage sensed high
    output logic clamp_below_o, // source below clamp threshold
    output logic neg_over_o, // negative supply below over threshold
    output logic neg_under_o, // negative supply above under threshold
    output logic pos_over_o, // positive supply above over threshold
    output logic pos_under_o, // positive supply below under threshold
    output logic clamp_sto_o, // collector clamp soft turn-off
    output logic [2:0] temp_hot_o, // temperature inputs over threshold
    output logic [2:0] short_o, // current inputs over short threshold
    output logic [2:0] overcur_o, // current inputs over overcurrent threshold
    output logic ilimit_o, // regulator current limit
    output logic rail_o, // internal rail event
    output logic reg_o, // regulator fault
    output logic desat_o // desaturation sense over threshold
);
    // ------------------------------------------------------------
    // comparator outputs
    // ------------------------------------------------------------
    localparam int PIN_DESAT_ALIAS = NPIN; // desat rides one bit above the pin vector
    logic [NPIN:0] pin_q = '0; // comparator states on the wires
    // comparators settle a few ns after the request, off the edge
    always @(posedge clk_i) begin
        pin_q <= #3 want_i;
    end
    // gate sensed on both stages
    assign source_level_o = pin_q[PIN_SRC];
    assign sink_level_o = pin_q[PIN_SINK];
    assign clamp_below_o = pin_q[PIN_CLAMP];
    assign neg_over_o = pin_q[PIN_NOV];
    assign neg_under_o = pin_q[PIN_NUV];
    assign pos_over_o = pin_q[PIN_POV];
    assign pos_under_o = pin_q[PIN_PUV];
    assign clamp_sto_o = pin_q[PIN_STO];
    assign temp_hot_o = pin_q[PIN_TEMP +: 3];
    assign short_o = pin_q[PIN_SC +: 3];
    assign overcur_o = pin_q[PIN_OC +: 3];
    assign ilimit_o = pin_q[PIN_ILIM];
    assign rail_o = pin_q[PIN_RAIL];
    assign reg_o = pin_q[PIN_REG];
    assign desat_o = pin_q[PIN_DESAT_ALIAS];
endmodule

// ### design/sfsw_pkg.sv
// Purpose: constants for the secondary fault status word block
// Assumes: 16-bit register data, word-indexed register port
// Notes: config, event and mask registers sit beside the status word
package sfsw_pkg;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_STATUS = 4'h0; // live status word, read only
    localparam logic [3:0] ADDR_CONFIG = 4'h1; // monitor enables and disables
    localparam logic [3:0] ADDR_EVENT = 4'h2; // sticky events, write one to clear
    localparam logic [3:0] ADDR_MASK = 4'h3; // interrupt mask, 1 = pass

    // ------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------
    localparam int ST_GATE_LEVEL = 15;
    localparam int ST_GATE_MISMATCH = 14;
    localparam int ST_INT_REG = 13;
    localparam int ST_INT_RAIL = 12;
    localparam int ST_MILLER = 11;
    localparam int ST_NEG_OVER = 10;
    localparam int ST_NEG_UNDER = 9;
    localparam int ST_POS_OVER = 8;
    localparam int ST_POS_UNDER = 7;
    localparam int ST_COLL_CLAMP = 6;
    localparam int ST_OVERTEMP = 5;
    localparam int ST_RESERVED = 4;
    localparam int ST_ILIMIT = 3;
    localparam int ST_SHORT = 2;
    localparam int ST_OVERCUR = 1;
    localparam int ST_DESAT = 0;

    // ------------------------------------------------------------
    // config word layout
    // ------------------------------------------------------------
    localparam int CF_NEG_EN = 0;
    localparam int CF_POS_OV_DIS = 1;
    localparam int CF_POS_UV_DIS = 2;
    localparam int CF_CLAMP_EN = 3;
    localparam int CF_TEMP_EN = 4; // three bits, inputs one, three, five
    localparam int CF_CUR_EN = 8; // three bits, inputs two, four, six
    localparam logic [15:0] CFG_WMASK = 16'h070f;

    // ------------------------------------------------------------
    // synchronised pin vector layout
    // ------------------------------------------------------------
    localparam int PIN_SRC = 0;
    localparam int PIN_SINK = 1;
    localparam int PIN_CLAMP = 2;
    localparam int PIN_NOV = 3;
    localparam int PIN_NUV = 4;
    localparam int PIN_POV = 5;
    localparam int PIN_PUV = 6;
    localparam int PIN_STO = 7;
    localparam int PIN_TEMP = 8;
    localparam int PIN_SC = 11;
    localparam int PIN_OC = 14;
    localparam int PIN_ILIM = 17;
    localparam int PIN_RAIL = 18;
    localparam int PIN_REG = 19;
    localparam int NPIN = 20;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [15:0] EVENT_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] EVENT_BITS = 16'h77ef; // fault bits only, no state bits
    localparam logic [2:0] GM_SETTLE_CYC = 3'h4; // cycles the gate may lag a new level

endpackage

// ### design/sfsw_status.sv
// Purpose: secondary side fault status word with config, events and interrupt
// Assumes: comparator inputs are asynchronous; drive_high_i is on clk_i
// Notes: the status word is live, sticky copies live in the event register
//
// Contract
// - bit 15 shows the sensed gate level, 0 low, 1 high
// - gate sensed on sink while driving high, on source while driving low
// - bit 14 set when sensed gate level differs from expected level, once the settle count reaches GM_SETTLE_CYC
// - bit 12 flags internal rail over/under voltage, bit 13 regulator fault
// - bit 11 is 1 while the miller clamp is engaged
// - bits 10 and 9 rise only while negative monitor enable is 1
// - bit 10 set when negative supply lies below its over threshold
// - bit 9 set when negative supply lies above its under threshold
// - bit 8 positive overvoltage, only while its disable bit is 0
// - bit 7 positive undervoltage, only while its disable bit is 0
// - bit 6 clamp soft turn-off, only while clamp enable is 1
// - bit 5 stays 0: CFG_WMASK clears the temperature enables on every config write, so no temperature input is ever enabled
// - bit 4 reserved, always reads zero
// - bit 3 set while the regulator current limit is active
// - bit 2 set when any enabled current input exceeds short threshold
// - bit 1 set when any enabled current input exceeds overcurrent threshold
// - bit 0 set when the desaturation sense exceeds its threshold
`timescale 1ns/1ns
module sfsw_status
    import sfsw_pkg::*;
(
    input wire logic clk_i, // 125 MHz clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic drive_high_i, // expected driver output level
    input wire logic source_level_i, // source output sensed high
    input wire logic sink_level_i, // sink output sensed high
    input wire logic clamp_below_i, // source output below clamp threshold
    input wire logic neg_over_cmp_i, // negative supply below over threshold
    input wire logic neg_under_cmp_i, // negative supply above under threshold
    input wire logic pos_over_cmp_i, // positive supply above over threshold
    input wire logic pos_under_cmp_i, // positive supply below under threshold
    input wire logic clamp_sto_i, // collector clamp started soft turn-off
    input wire logic [2:0] temp_hot_i, // temperature inputs one, three, five hot
    input wire logic [2:0] short_cmp_i, // current inputs over short threshold
    input wire logic [2:0] overcur_cmp_i, // current inputs over overcurrent threshold
    input wire logic reg_ilimit_i, // regulator current limit active
    input wire logic rail_fault_i, // internal rail over or under voltage
    input wire logic reg_fault_i, // internal regulator fault
    input wire logic desat_cmp_i, // desaturation sense over threshold
    input wire logic [ADDR_W-1:0] addr_i, // register index
    input wire logic [DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [DATA_W-1:0] rdata_o, // read data, cycle after strobe
    output logic [DATA_W-1:0] status_o, // live status word
    output logic irq_o // level interrupt
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q, sync1_d;
    logic [NPIN-1:0] sync2_q, sync2_d;
    logic drv_q, drv_d;
    logic [2:0] gm_cnt_q, gm_cnt_d;
    logic gate_seen;
    logic gm_settled;
    logic [DATA_W-1:0] status_q, status_d;
    logic [DATA_W-1:0] config_q, config_d;
    logic [DATA_W-1:0] event_q, event_d;
    logic [DATA_W-1:0] mask_q, mask_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic [DATA_W-1:0] rise;
    logic [DATA_W-1:0] clr;
    logic desat_s1_q, desat_s2_q;

    // pin gathering into one vector
    assign pin_raw = {reg_fault_i, rail_fault_i, reg_ilimit_i, overcur_cmp_i,
                      short_cmp_i, temp_hot_i, clamp_sto_i, pos_under_cmp_i,
                      pos_over_cmp_i, neg_under_cmp_i, neg_over_cmp_i,
                      clamp_below_i, sink_level_i, source_level_i};

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    // two stages; only the second stage feeds logic
    always_comb begin
        sync1_d = pin_raw;
        sync2_d = sync1_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ------------------------------------------------------------
    // gate monitor
    // ------------------------------------------------------------
    // sense the output that is not driving, so a stuck gate shows up
    assign gate_seen = drive_high_i ? sync2_q[PIN_SINK] : sync2_q[PIN_SRC];
    assign gm_settled = (gm_cnt_q == GM_SETTLE_CYC);

    // settle counter hides mismatch from the cycle after a drive change while the gate and synchroniser catch up
    always_comb begin
        drv_d = drive_high_i;
        if (drive_high_i != drv_q) begin
            gm_cnt_d = 3'h0;
        end else if (gm_settled) begin
            gm_cnt_d = gm_cnt_q;
        end else begin
            gm_cnt_d = gm_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_q <= 1'b0;
            gm_cnt_q <= 3'h0;
        end else begin
            drv_q <= drv_d;
            gm_cnt_q <= gm_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    // every bit is recomputed each cycle; the bus never writes it
    always_comb begin
        status_d = STATUS_RST;
        status_d[ST_GATE_LEVEL] = gate_seen;
        status_d[ST_GATE_MISMATCH] = gm_settled && (gate_seen != drive_high_i);
        status_d[ST_INT_REG] = sync2_q[PIN_REG];
        status_d[ST_INT_RAIL] = sync2_q[PIN_RAIL];
        status_d[ST_MILLER] = sync2_q[PIN_CLAMP];
        status_d[ST_NEG_OVER] = config_q[CF_NEG_EN] && sync2_q[PIN_NOV];
        status_d[ST_NEG_UNDER] = config_q[CF_NEG_EN] && sync2_q[PIN_NUV];
        status_d[ST_POS_OVER] = !config_q[CF_POS_OV_DIS] && sync2_q[PIN_POV];
        status_d[ST_POS_UNDER] = !config_q[CF_POS_UV_DIS] && sync2_q[PIN_PUV];
        status_d[ST_COLL_CLAMP] = config_q[CF_CLAMP_EN] && sync2_q[PIN_STO];
        status_d[ST_OVERTEMP] = |(sync2_q[PIN_TEMP +: 3] & config_q[CF_TEMP_EN +: 3]);
        status_d[ST_RESERVED] = 1'b0;
        status_d[ST_ILIMIT] = sync2_q[PIN_ILIM];
        status_d[ST_SHORT] = |(sync2_q[PIN_SC +: 3] & config_q[CF_CUR_EN +: 3]);
        status_d[ST_OVERCUR] = |(sync2_q[PIN_OC +: 3] & config_q[CF_CUR_EN +: 3]);
        status_d[ST_DESAT] = desat_s2_q;
    end

    // desaturation comparator sits outside the pin vector, so it has its own pair
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            desat_s1_q <= 1'b0;
            desat_s2_q <= 1'b0;
        end else begin
            desat_s1_q <= desat_cmp_i;
            desat_s2_q <= desat_s1_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // config, event, mask and interrupt
    // ------------------------------------------------------------
    // a fault bit going high is an event; a new event beats a clear
    always_comb begin
        rise = status_d & ~status_q & EVENT_BITS;
        clr = '0;
        config_d = config_q;
        mask_d = mask_q;
        if (wr_i) begin
            case (addr_i)
                ADDR_CONFIG: config_d = wdata_i & CFG_WMASK;
                ADDR_EVENT: clr = wdata_i;
                ADDR_MASK: mask_d = wdata_i & EVENT_BITS;
                default: clr = '0; // status word and unmapped: no effect
            endcase
        end
        event_d = (event_q & ~clr) | rise;
        irq_d = |(event_d & mask_d);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_q <= CONFIG_RST;
            event_q <= EVENT_RST;
            mask_q <= MASK_RST;
            irq_q <= 1'b0;
        end else begin
            config_q <= config_d;
            event_q <= event_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // data stand for one cycle after the read strobe, zero otherwise
    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_STATUS: rdata_d = status_q;
                ADDR_CONFIG: rdata_d = config_q;
                ADDR_EVENT: rdata_d = event_q;
                ADDR_MASK: rdata_d = mask_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign status_o = status_q;
    assign irq_o = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // gate level follows the inactive output of the expected level
    property p_gate_level;
        drive_high_i && sync2_q[PIN_SINK] |=> status_q[ST_GATE_LEVEL];
    endproperty
    a_gate_level: assert property (p_gate_level) else $error("gate level lost");

    property p_gate_sense;
        !drive_high_i |=> status_q[ST_GATE_LEVEL] == $past(sync2_q[PIN_SRC]);
    endproperty
    a_gate_sense: assert property (p_gate_sense) else $error("wrong output sensed");

    property p_mismatch;
        $stable(drive_high_i) [*6] ##0 (gate_seen != drive_high_i)
            |=> status_q[ST_GATE_MISMATCH];
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch missed");

    property p_neg_gate;
        !config_q[CF_NEG_EN] |=> !status_q[ST_NEG_OVER] && !status_q[ST_NEG_UNDER];
    endproperty
    a_neg_gate: assert property (p_neg_gate) else $error("neg flag while off");

    property p_pos_over;
        config_q[CF_POS_OV_DIS] |=> !status_q[ST_POS_OVER];
    endproperty
    a_pos_over: assert property (p_pos_over) else $error("pos over while off");

    property p_pos_under;
        !config_q[CF_POS_UV_DIS] && sync2_q[PIN_PUV] |=> status_q[ST_POS_UNDER];
    endproperty
    a_pos_under: assert property (p_pos_under) else $error("pos under missed");

    property p_clamp;
        !config_q[CF_CLAMP_EN] |=> !status_q[ST_COLL_CLAMP];
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp flag while off");

    property p_short;
        (sync2_q[PIN_SC +: 3] & config_q[CF_CUR_EN +: 3]) != 3'h0 |=> status_q[ST_SHORT];
    endproperty
    a_short: assert property (p_short) else $error("short missed");

    property p_desat;
        desat_cmp_i [*3] |=> status_q[ST_DESAT];
    endproperty
    a_desat: assert property (p_desat) else $error("desat missed");

    property p_reserved;
        rd_i && addr_i == ADDR_STATUS |=> rdata_o == $past(status_q) && !rdata_o[ST_RESERVED];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_sticky;
        rise[ST_OVERCUR] |=> event_q[ST_OVERCUR] && (!mask_q[ST_OVERCUR] || irq_o);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event lost");

    property p_match;
        gate_seen == drive_high_i |=> !status_q[ST_GATE_MISMATCH];
    endproperty
    a_match: assert property (p_match) else $error("false mismatch");

    property p_rail;
        1'b1 |=> status_q[ST_INT_RAIL] == $past(sync2_q[PIN_RAIL])
            && status_q[ST_INT_REG] == $past(sync2_q[PIN_REG]);
    endproperty
    a_rail: assert property (p_rail) else $error("rail or regulator flag wrong");

    property p_miller;
        sync2_q[PIN_CLAMP] |=> status_q[ST_MILLER];
    endproperty
    a_miller: assert property (p_miller) else $error("clamp state missed");

    property p_neg_over;
        config_q[CF_NEG_EN] && sync2_q[PIN_NOV] |=> status_q[ST_NEG_OVER];
    endproperty
    a_neg_over: assert property (p_neg_over) else $error("neg over missed");

    property p_neg_under;
        config_q[CF_NEG_EN] && sync2_q[PIN_NUV] |=> status_q[ST_NEG_UNDER];
    endproperty
    a_neg_under: assert property (p_neg_under) else $error("neg under missed");

    property p_overtemp;
        (sync2_q[PIN_TEMP +: 3] & config_q[CF_TEMP_EN +: 3]) != 3'h0 |=> status_q[ST_OVERTEMP];
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemp missed");

    property p_ilimit;
        sync2_q[PIN_ILIM] |=> status_q[ST_ILIMIT];
    endproperty
    a_ilimit: assert property (p_ilimit) else $error("current limit missed");

    property p_overcur;
        (sync2_q[PIN_OC +: 3] & config_q[CF_CUR_EN +: 3]) != 3'h0 |=> status_q[ST_OVERCUR];
    endproperty
    a_overcur: assert property (p_overcur) else $error("overcurrent missed");

    c_irq: cover property (rise[ST_DESAT] ##1 irq_o);
    c_neg_flag: cover property (status_q[ST_NEG_OVER] || status_q[ST_NEG_UNDER]);
    c_short_irq: cover property (status_q[ST_SHORT] && irq_o);
    c_clear: cover property (wr_i && addr_i == ADDR_EVENT ##1 !irq_o);
    c_mismatch: cover property (status_q[ST_GATE_MISMATCH]);

endmodule
